// ==== design/dcf_regs.svh ====
// Constants for the dual-clock FIFO channel with programmable flags
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// Data path width of one channel
`define DCF_DATA_W 9
// Width of one offset register
`define DCF_OFS_W 8
// Default storage depth in words
`define DCF_DEPTH_DEF 256
// Offset register reset values: low byte and high byte
`define DCF_OFS_DEF_LOW 8'h07
`define DCF_OFS_DEF_HIGH 8'h00
// Output register reset value
`define DCF_DOUT_RST 9'h000
// Offset register selector width and first selector
`define DCF_SEL_W 2
`define DCF_SEL_FIRST 2'h0
// Number of offset registers in the bank
`define DCF_OFS_COUNT 4
// Pointer reset value, first storage location
`define DCF_PTR_RST 0

`endif

// ==== design/dcf_pkg.sv ====
// Types and pointer code helpers for the dual-clock FIFO channel
package dcf_pkg;

    // Use of the dual-purpose write enable pin, caught on the first edge after reset release
    typedef enum logic [0:0] {
        DCF_MODE_PROG = 1'b0,
        DCF_MODE_DUAL = 1'b1
    } dcf_mode_t;

    // Offset register order in the rotating sequence
    typedef enum logic [1:0] {
        DCF_SEL_EMPTY_LOW = 2'b00,
        DCF_SEL_EMPTY_HIGH = 2'b01,
        DCF_SEL_FULL_LOW = 2'b10,
        DCF_SEL_FULL_HIGH = 2'b11
    } dcf_sel_t;

    // Binary to Gray code
    function automatic logic [12:0] dcf_bin2gray(input logic [12:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary code
    function automatic logic [12:0] dcf_gray2bin(input logic [12:0] g);
        logic [12:0] b;
        b = g;
        for (int i = 11; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ==== design/dcf_ofs_if.sv ====
// Carrier between the FIFO core and its offset register bank
`timescale 1ns/1ps
`default_nettype none
interface dcf_ofs_if;
    logic wr_stb;          // Load the next offset register
    logic [7:0] wr_data;   // Byte to load
    logic rd_stb;          // Advance the read selector
    logic [7:0] rd_data;   // Register under the read selector
    logic [15:0] empty_ofs; // Empty offset, high and low bytes
    logic [15:0] full_ofs;  // Full offset, high and low bytes

    // FIFO core side
    modport core (output wr_stb, output wr_data, output rd_stb,
                  input rd_data, input empty_ofs, input full_ofs);
    // Register bank side
    modport bank (input wr_stb, input wr_data, input rd_stb,
                  output rd_data, output empty_ofs, output full_ofs);
endinterface
`default_nettype wire

// ==== design/dcf_sync.sv ====
// Gray-coded pointer carrier with a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module dcf_sync
    import dcf_pkg::*;
#(
    parameter int PW = 9
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [PW-1:0] ptr_bin,
    output logic [PW-1:0] ptr_sync
);
    logic [12:0] wide_in;   // Pointer widened for the helpers
    logic [12:0] wide_out;  // Decoded pointer, widened
    logic [12:0] gray_wide; // Gray code of the widened pointer
    logic [PW-1:0] gray_src; // Gray code launched from the source
    logic [PW-1:0] stage1;  // First synchroniser flop
    logic [PW-1:0] stage2;  // Second synchroniser flop

    assign wide_in = 13'(ptr_bin);
    assign gray_wide = dcf_bin2gray(wide_in);
    assign wide_out = dcf_gray2bin(13'(stage2));
    assign ptr_sync = wide_out[PW-1:0];

    ////////////////////////////////////////////////////////////////////
    // Launch Gray code, then two flops; only stage2 is decoded
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gray_src <= '0;
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            // Upper bits are zero, the pointer is zero-extended
            gray_src <= gray_wide[PW-1:0];
            stage1 <= gray_src;
            stage2 <= stage1;
        end
    end
endmodule
`default_nettype wire

// ==== design/dcf_offsets.sv ====
// Bank of four offset registers with rotating load and read order
`timescale 1ns/1ps
`default_nettype none
module dcf_offsets
    import dcf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    dcf_ofs_if.bank ofs
);
    `include "dcf_regs.svh"

    logic [`DCF_OFS_W-1:0] bank [`DCF_OFS_COUNT]; // Offset registers
    dcf_sel_t wr_sel; // Next register to load
    dcf_sel_t rd_sel; // Next register to show

    // Register under the read selector
    assign ofs.rd_data = bank[rd_sel];
    assign ofs.empty_ofs = {bank[DCF_SEL_EMPTY_HIGH], bank[DCF_SEL_EMPTY_LOW]};
    assign ofs.full_ofs = {bank[DCF_SEL_FULL_HIGH], bank[DCF_SEL_FULL_LOW]};

    ////////////////////////////////////////////////////////////////////
    // One process per register; low bytes default to seven
    for (genvar g = 0; g < `DCF_OFS_COUNT; g++) begin : g_reg
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                bank[g] <= (g[0] == 1'b0) ? `DCF_OFS_DEF_LOW
                                          : `DCF_OFS_DEF_HIGH;
            end else if (ofs.wr_stb && wr_sel == dcf_sel_t'(g)) begin
                bank[g] <= ofs.wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selectors wrap after the fourth register and keep their place
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_sel <= dcf_sel_t'(`DCF_SEL_FIRST);
            rd_sel <= dcf_sel_t'(`DCF_SEL_FIRST);
        end else begin
            if (ofs.wr_stb) begin
                wr_sel <= dcf_sel_t'(wr_sel + 2'h1);
            end
            if (ofs.rd_stb) begin
                rd_sel <= dcf_sel_t'(rd_sel + 2'h1);
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/dcf_fifo.sv ====
// One FIFO channel: storage, pointers, flags and offset access
`timescale 1ns/1ps
`default_nettype none
`include "dcf_regs.svh"
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DEPTH = `DCF_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_clk,
    input wire logic rd_clk,
    input wire logic [8:0] din,
    input wire logic wr_en1_n,
    input wire logic wr_en2_load,
    input wire logic rd_en1_n,
    input wire logic rd_en2_n,
    input wire logic out_en_n,
    output logic [8:0] dout,
    output logic dout_oe,
    output logic full_n,
    output logic empty_n,
    output logic almost_full_n,
    output logic almost_empty_n
);
    ////////////////////////////////////////////////////////////////////
    // Sizes
    // The pointer wrap bit tells a full array from an empty one

    localparam int AW = $clog2(DEPTH); // Address bits
    localparam int PW = AW + 1;        // Pointer bits with wrap bit
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH); // Full count
    localparam logic [PW-1:0] ONE_P = PW'(1);       // Pointer step
    localparam logic [PW-1:0] ZERO_P = PW'(`DCF_PTR_RST); // Start

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic [`DCF_DATA_W-1:0] mem [DEPTH]; // Storage array
    logic wr_clk_q;            // Previous write clock level
    logic rd_clk_q;            // Previous read clock level
    logic mode_valid;          // Strap has been caught
    dcf_mode_t mode;           // Caught write mode
    logic [PW-1:0] wptr;       // Write pointer
    logic [PW-1:0] rptr;       // Read pointer
    logic [PW-1:0] wptr_s;     // Write pointer seen by read side
    logic [PW-1:0] rptr_s;     // Read pointer seen by write side
    logic [`DCF_DATA_W-1:0] out_reg; // Output register

    dcf_ofs_if ofs (); // Offset bank carrier

    // Occupancy from a leading and a trailing pointer; the wrap
    // bit makes the difference exact up to DEPTH
    function automatic logic [PW-1:0] fill_of(input logic [PW-1:0] lead,
            input logic [PW-1:0] trail);
        return lead - trail;
    endfunction

    // Pointer after a cycle: one step on an accepted transfer
    function automatic logic [PW-1:0] step_of(input logic [PW-1:0] p,
            input logic go);
        return go ? p + ONE_P : p;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Clock pin edges, taken as enable pulses

    wire wr_tick = wr_clk & ~wr_clk_q; // Write clock rising edge
    wire rd_tick = rd_clk & ~rd_clk_q; // Read clock rising edge

    // Previous levels start high: a pin already high at release
    // shows no edge, and the idle low level shows none either
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // High, so no false edge
            wr_clk_q <= 1'b1;
            rd_clk_q <= 1'b1;
        end else begin
            // Follow the pin levels
            wr_clk_q <= wr_clk;
            rd_clk_q <= rd_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap capture on the first edge after reset release

    // An async reset cannot catch a pin, so the strap must still
    // stand at the first edge; no transfer is taken at that edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // No mode yet, transfers blocked
            mode_valid <= 1'b0;
            mode <= DCF_MODE_DUAL;
        end else if (!mode_valid) begin
            // First edge after release
            mode_valid <= 1'b1;
            mode <= wr_en2_load ? DCF_MODE_DUAL : DCF_MODE_PROG;
        end
    end

    wire prog_mode = mode_valid & (mode == DCF_MODE_PROG); // Flag mode

    ////////////////////////////////////////////////////////////////////
    // Write side decode

    // same enable pair
    // Both modes store on enable one low and pin two high
    wire write_req = wr_tick & mode_valid & ~wr_en1_n & wr_en2_load;
    // ignore when full
    // Registered full flag, so a freed slot waits for a tick
    wire write_go = write_req & full_n;
    // offset load strobe
    // Flag mode only; in dual mode a low pin two just blocks
    wire load_go = wr_tick & prog_mode & ~wr_en1_n & ~wr_en2_load;

    // Write pointer after this cycle
    wire [PW-1:0] next_wptr = step_of(wptr, write_go);
    // Words seen at write, the word stored now included
    wire [PW-1:0] wr_count = fill_of(next_wptr, rptr_s);
    // offset m, default seven
    // Offset cut to address width so the level never wraps
    wire [PW-1:0] full_m = PW'(ofs.full_ofs[AW-1:0]);
    // Almost-full level, DEPTH minus m
    wire [PW-1:0] af_level = DEPTH_P - full_m;
    wire next_full_n = (wr_count != DEPTH_P);
    // Low from the almost-full level up to full
    wire next_almost_full_n = (wr_count < af_level);

    ////////////////////////////////////////////////////////////////////
    // Read side decode

    // Both read enables low at a read tick
    wire rd_both = rd_tick & ~rd_en1_n & ~rd_en2_n;
    // offset read strobe
    // Not blocked by empty and leaves the read pointer alone
    wire ofs_rd_go = rd_both & prog_mode & ~wr_en2_load;
    wire read_go = rd_both & empty_n & ~ofs_rd_go;

    // Read pointer after this cycle
    wire [PW-1:0] next_rptr = step_of(rptr, read_go);
    // Words seen at read, the word taken now excluded
    wire [PW-1:0] rd_count = fill_of(wptr_s, next_rptr);
    // offset n, default seven
    // Cut to address width like the full offset
    wire [PW-1:0] empty_n_ofs = PW'(ofs.empty_ofs[AW-1:0]);
    // Empty when no word is left
    wire next_empty_n = (rd_count != ZERO_P);
    // Low while at most n words are held
    wire next_almost_empty_n = (rd_count > empty_n_ofs);

    ////////////////////////////////////////////////////////////////////
    // Offset bank hookup
    // Only the low byte of din reaches an offset register

    assign ofs.wr_stb = load_go;
    assign ofs.wr_data = din[`DCF_OFS_W-1:0];
    assign ofs.rd_stb = ofs_rd_go;

    dcf_offsets u_offsets (
        .clk_sys(clk_sys),
        .rst(rst),
        .ofs(ofs)
    );

    ////////////////////////////////////////////////////////////////////
    // Pointer crossings

    // Write pointer into the read side
    // Gray two-flop crossing
    dcf_sync #(.PW(PW)) u_wsync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ptr_bin(wptr),
        .ptr_sync(wptr_s)
    );

    // Read pointer into the write side
    dcf_sync #(.PW(PW)) u_rsync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ptr_bin(rptr),
        .ptr_sync(rptr_s)
    );

    ////////////////////////////////////////////////////////////////////
    // Storage write, no reset on the array
    // The full check is already folded into write_go

    always_ff @(posedge clk_sys) begin
        if (write_go) begin
            mem[wptr[AW-1:0]] <= din;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointers

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wptr <= ZERO_P;
            rptr <= ZERO_P;
        end else begin
            // Step on accepted transfers only
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write-side flags, moved only on write clock edges
    // They count the word stored at the same tick; a freed slot
    // shows at the first write tick after the crossing

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            full_n <= 1'b1;
            almost_full_n <= 1'b1;
        end else if (wr_tick) begin
            full_n <= next_full_n;
            almost_full_n <= next_almost_full_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-side flags, moved only on read clock edges
    // The write pointer is seen three cycles late

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            empty_n <= 1'b0;
            almost_empty_n <= 1'b0;
        end else if (rd_tick) begin
            empty_n <= next_empty_n;
            almost_empty_n <= next_almost_empty_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output register: data word, offset byte, or hold
    // Reads and offset reads never fall in one cycle, and with
    // neither the register keeps its last value

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_reg <= `DCF_DOUT_RST;
        end else if (read_go) begin
            out_reg <= mem[rptr[AW-1:0]];
        end else if (ofs_rd_go) begin
            out_reg <= {1'b0, ofs.rd_data};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output drive
    // No high-impedance value inside; the pad uses dout_oe

    assign dout_oe = ~out_en_n;
    assign dout = out_reg;

endmodule
`default_nettype wire

// ==== tb/dcf_fifo_properties.sv ====
// Port checks for one FIFO channel
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_properties #(
    parameter int DEPTH = 256
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_clk,
    input wire logic rd_clk,
    input wire logic wr_en2_load,
    input wire logic rd_en1_n,
    input wire logic rd_en2_n,
    input wire logic out_en_n,
    input wire logic [8:0] dout,
    input wire logic dout_oe,
    input wire logic full_n,
    input wire logic empty_n,
    input wire logic almost_full_n,
    input wire logic almost_empty_n
);
    logic wr_q; // Last write clock level
    logic rd_q; // Last read clock level
    logic wr_tick;
    logic rd_tick;
    ////////////////////////////////////////////////////////////////////
    // Clock pin edge finders, high level at reset gives no edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q <= 1'h1;
            rd_q <= 1'h1;
        end else begin
            wr_q <= wr_clk;
            rd_q <= rd_clk;
        end
    end
    assign wr_tick = wr_clk & ~wr_q;
    assign rd_tick = rd_clk & ~rd_q;
    default clocking dcf_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    a_reset_values: assert property (disable iff (1'h0)
        rst |-> full_n && almost_full_n && !empty_n && !almost_empty_n
        && dout == 9'h000) else $error("reset values wrong");
    a_oe_follows: assert property (dout_oe == !out_en_n)
        else $error("output enable wrong");
    a_wr_flags_hold: assert property (!wr_tick |=>
        $stable(full_n) && $stable(almost_full_n))
        else $error("write flags moved off tick");
    a_rd_flags_hold: assert property (!rd_tick |=>
        $stable(empty_n) && $stable(almost_empty_n))
        else $error("read flags moved off tick");
    a_dout_hold: assert property ((!rd_tick || rd_en1_n || rd_en2_n)
        |=> $stable(dout)) else $error("output moved without read");
    a_empty_blocks: assert property (rd_tick && !empty_n && wr_en2_load
        |=> $stable(dout)) else $error("read while empty");
    a_full_implies_af: assert property (!full_n |-> !almost_full_n)
        else $error("full without almost full");
    a_empty_implies_ae: assert property (!empty_n |-> !almost_empty_n)
        else $error("empty without almost empty");
    c_full: cover property (!full_n);
    c_ae_rise: cover property ($rose(almost_empty_n));
    c_ofs_read: cover property (rd_tick && !wr_en2_load && !rd_en1_n);
endmodule
bind dcf_fifo dcf_fifo_properties #(.DEPTH(DEPTH)) u_props (
    .clk_sys(clk_sys), .rst(rst), .wr_clk(wr_clk), .rd_clk(rd_clk),
    .wr_en2_load(wr_en2_load), .rd_en1_n(rd_en1_n), .rd_en2_n(rd_en2_n),
    .out_en_n(out_en_n), .dout(dout), .dout_oe(dout_oe), .full_n(full_n),
    .empty_n(empty_n), .almost_full_n(almost_full_n),
    .almost_empty_n(almost_empty_n));
`default_nettype wire

// ==== tb/dcf_far.sv ====
// Writer and reader logic model for one FIFO channel
`timescale 1ns/1ps
`default_nettype none
module dcf_far (
    input wire logic clk_sys,
    output logic wr_clk,
    output logic rd_clk,
    output logic [8:0] din,
    output logic wr_en1_n,
    output logic wr_en2_load,
    output logic rd_en1_n,
    output logic rd_en2_n
);
    // Idle levels, clocks stand low between cycles
    initial begin
        wr_clk = 1'h0;
        rd_clk = 1'h0;
        din = 9'h000;
        wr_en1_n = 1'h1;
        wr_en2_load = 1'h0;
        rd_en1_n = 1'h1;
        rd_en2_n = 1'h1;
    end
    // One write clock pulse, qualifiers held over the sampling edge
    // write and load cycle
    task automatic wr_cyc(input logic e1, input logic ld,
                          input logic [8:0] d);
        @(posedge clk_sys);
        din <= d;
        wr_en1_n <= e1;
        wr_en2_load <= ld;
        wr_clk <= 1'h1;
        @(posedge clk_sys);
        wr_clk <= 1'h0;
        wr_en1_n <= 1'h1;
        din <= ~d;
        @(negedge clk_sys);
    endtask
    // One read clock pulse, never overlapping a write
    // read cycle apart from loads
    task automatic rd_cyc(input logic e, input logic ld);
        @(posedge clk_sys);
        rd_en1_n <= e;
        rd_en2_n <= e;
        wr_en2_load <= ld;
        rd_clk <= 1'h1;
        @(posedge clk_sys);
        rd_clk <= 1'h0;
        rd_en1_n <= 1'h1;
        rd_en2_n <= 1'h1;
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== tb/dual_clock_fifo_prog_flags_tb.sv ====
// Self-checking bench for one FIFO channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module dual_clock_fifo_prog_flags_tb;
    localparam int D = 256; // Depth under test
    typedef struct {int cnt; logic [3:0] fl;} dcf_row_t;
    // Fill count beside flags {full, almost full, empty, almost empty}
    dcf_row_t rows [7] = '{'{1, 4'he}, '{7, 4'he}, '{8, 4'hf},
        '{D - 8, 4'hf}, '{D - 7, 4'hb}, '{D - 1, 4'hb}, '{D, 4'h3}};
    logic [8:0] ofs_exp [5] = '{9'h002, 9'h000, 9'h0fa, 9'h000, 9'h002};
    logic clk_sys;
    logic rst;
    logic out_en_n;
    logic wr_clk, rd_clk, wr_en1_n, wr_en2_load, rd_en1_n, rd_en2_n;
    logic [8:0] din;
    logic [8:0] dout;
    logic dout_oe, full_n, empty_n, almost_full_n, almost_empty_n;
    logic [3:0] fl;
    int n_errors = 0;
    int n_tests = 0;
    int nw = 0; // Words written since reset
    assign fl = {full_n, almost_full_n, empty_n, almost_empty_n};
    dcf_far far (.clk_sys(clk_sys), .wr_clk(wr_clk), .rd_clk(rd_clk),
        .din(din), .wr_en1_n(wr_en1_n), .wr_en2_load(wr_en2_load),
        .rd_en1_n(rd_en1_n), .rd_en2_n(rd_en2_n));
    dcf_fifo #(.DEPTH(D)) dut (.clk_sys(clk_sys), .rst(rst),
        .wr_clk(wr_clk), .rd_clk(rd_clk), .din(din), .wr_en1_n(wr_en1_n),
        .wr_en2_load(wr_en2_load), .rd_en1_n(rd_en1_n),
        .rd_en2_n(rd_en2_n), .out_en_n(out_en_n), .dout(dout),
        .dout_oe(dout_oe), .full_n(full_n), .empty_n(empty_n),
        .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n));
    ////////////////////////////////////////////////////////////////////
    // 50 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Reset with the mode strap held past release
    task automatic do_reset(input logic strap);
        @(posedge clk_sys);
        rst <= 1'h1;
        far.wr_en2_load <= strap;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK({fl, dout}, {4'hc, 9'h000})
        @(posedge clk_sys);
        rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        nw = 0;
    endtask
    // Idle ticks on both sides so pointers cross over
    task automatic settle();
        repeat (3) begin
            far.rd_cyc(1'h1, 1'h1);
            far.wr_cyc(1'h1, 1'h1, 9'h000);
        end
    endtask
    // Write up to a fill count, then look at the flags
    task automatic fill(input int cnt, input logic [3:0] exp);
        while (nw < cnt) begin
            far.wr_cyc(1'h0, 1'h1, 9'(nw) ^ 9'h155);
            nw++;
        end
        settle();
        `CHK(fl, exp)
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence, first writes only after a reset
    initial begin
        rst = 1'h1;
        out_en_n = 1'h0;
        do_reset(1'h0);
        // Offset loads with a pause, then a wrap to the first register
        far.wr_cyc(1'h0, 1'h0, 9'h003);
        far.wr_cyc(1'h0, 1'h0, 9'h000);
        far.wr_cyc(1'h1, 1'h1, 9'h000);
        far.wr_cyc(1'h0, 1'h0, 9'h0fa);
        far.wr_cyc(1'h0, 1'h0, 9'h000);
        far.wr_cyc(1'h0, 1'h0, 9'h002);
        for (int i = 0; i < 5; i++) begin
            far.rd_cyc(1'h0, 1'h0);
            `CHK(dout, ofs_exp[i])
        end
        fill(2, 4'he);
        fill(3, 4'hf);
        fill(5, 4'hf);
        fill(6, 4'hb);
        // Defaults come back after reset
        do_reset(1'h0);
        for (int r = 0; r < 7; r++) begin
            fill(rows[r].cnt, rows[r].fl);
        end
        far.wr_cyc(1'h0, 1'h1, 9'h0aa);
        far.rd_cyc(1'h0, 1'h1);
        `CHK(dout, 9'h155)
        settle();
        `CHK(full_n, 1'h1)
        for (int i = 1; i < D; i++) begin
            far.rd_cyc(1'h0, 1'h1);
            `CHK(dout, 9'(i) ^ 9'h155)
        end
        settle();
        far.rd_cyc(1'h0, 1'h1);
        `CHK({empty_n, dout}, {1'h0, 9'(D - 1) ^ 9'h155})
        // Dual enable mode
        do_reset(1'h1);
        far.wr_cyc(1'h0, 1'h0, 9'h0aa);
        far.wr_cyc(1'h1, 1'h1, 9'h0bb);
        settle();
        `CHK(fl, 4'hc)
        fill(1, 4'he);
        far.rd_cyc(1'h0, 1'h0);
        `CHK(dout, 9'h155)
        `CHK(dout_oe, 1'h1)
        @(posedge clk_sys);
        out_en_n <= 1'h1;
        @(negedge clk_sys);
        `CHK(dout_oe, 1'h0)
        tally_and_finish();
    end
    // Hang guard
    initial begin
        #1000000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
